/* File: core/cfbp_field_decode.sv */
/*
 decodes one 4-bit destination field into buffer number or fifo route.
 assumes the field comes from a register.
*/
`timescale 1ns/1ps
`include "cfbp_regs.svh"
module cfbp_field_decode (
   input  wire logic [3:0]            field_i,
   output cfbp_pkg::cfbp_route_s      route_o
);
   import cfbp_pkg::*;
   wire is_fifo = (field_i == `CFBP_FIFO_CODE);
   assign route_o.to_fifo    = is_fifo;
   assign route_o.buffer_num = field_i;
endmodule : cfbp_field_decode

/* File: core/cfbp_filter_dest.sv */
/*
 filter 4..11 destination select registers on a classic wishbone slave,
 plus hit routing of a matched filter to buffer or fifo.
 assumes synchronous active high reset and single clock at 100 MHz.
*/
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cfbp_regs.svh"
module cfbp_filter_dest #(
   parameter int ADDR_W = 4
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADDR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o,
   input  wire logic                 hit_i,
   input  wire logic [3:0]           hit_filter_i,
   output logic                      store_o,
   output logic                      store_fifo_o,
   output logic      [3:0]           store_buffer_o,
   output cfbp_pkg::cfbp_word_t      dest_4_to_7_o,
   output cfbp_pkg::cfbp_word_t      dest_8_to_11_o
);
   import cfbp_pkg::*;
   if (ADDR_W < 3) begin : g_addr_w_check
      $error("ADDR_W too small for register map");
   end
   // ****************************************
   // registers
   // ****************************************
   cfbp_word_t filter_4_to_7_dest_select_reg;
   cfbp_word_t filter_8_to_11_dest_select_reg;
   cfbp_word_t f47_next;
   cfbp_word_t f811_next;
   logic       ack_reg;
   logic       err_reg;
   logic [31:0] rdat_reg;
   logic       store_reg;
   logic       fifo_reg;
   logic [3:0] buf_reg;
   // ****************************************
   // bus decode
   // ****************************************
   wire        req      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   wire        sel_f47  = (wb_adr_i == ADDR_W'(`CFBP_OFS_F4TO7));
   wire        sel_f811 = (wb_adr_i == ADDR_W'(`CFBP_OFS_F8TO11));
   wire        mapped   = sel_f47 | sel_f811;
   wire        wr_f47   = req & wb_we_i & sel_f47;
   wire        wr_f811  = req & wb_we_i & sel_f811;
   wire [15:0] lane_msk = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0] rd_word  = sel_f47 ? filter_4_to_7_dest_select_reg :
                          (sel_f811 ? filter_8_to_11_dest_select_reg : 16'h0000);
   assign f47_next  = (filter_4_to_7_dest_select_reg & ~lane_msk) |
                      (wb_dat_i[15:0] & lane_msk);
   assign f811_next = (filter_8_to_11_dest_select_reg & ~lane_msk) |
                      (wb_dat_i[15:0] & lane_msk);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filter_4_to_7_dest_select_reg  <= `CFBP_RST_F4TO7;
         filter_8_to_11_dest_select_reg <= `CFBP_RST_F8TO11;
      end else begin
         if (wr_f47) filter_4_to_7_dest_select_reg <= f47_next;
         if (wr_f811) filter_8_to_11_dest_select_reg <= f811_next;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         err_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg  <= req & mapped;
         err_reg  <= req & ~mapped;
         rdat_reg <= {16'h0000, rd_word};
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdat_reg;
   assign dest_4_to_7_o  = filter_4_to_7_dest_select_reg;
   assign dest_8_to_11_o = filter_8_to_11_dest_select_reg;
   // ****************************************
   // field extraction
   // ****************************************
   cfbp_dest_t filter4_destination;
   cfbp_dest_t filter5_destination;
   cfbp_dest_t filter6_destination;
   cfbp_dest_t filter7_destination;
   cfbp_dest_t filter8_destination;
   cfbp_dest_t filter9_destination;
   cfbp_dest_t filter10_destination;
   cfbp_dest_t filter11_destination;
   assign filter4_destination  = filter_4_to_7_dest_select_reg[3:0];
   assign filter5_destination  = filter_4_to_7_dest_select_reg[7:4];
   assign filter6_destination  = filter_4_to_7_dest_select_reg[11:8];
   assign filter7_destination  = filter_4_to_7_dest_select_reg[15:12];
   assign filter8_destination  = filter_8_to_11_dest_select_reg[3:0];
   assign filter9_destination  = filter_8_to_11_dest_select_reg[7:4];
   assign filter10_destination = filter_8_to_11_dest_select_reg[11:8];
   assign filter11_destination = filter_8_to_11_dest_select_reg[15:12];
   // ****************************************
   // hit routing
   // ****************************************
   cfbp_hit_if hit_bus ();
   assign hit_bus.hit    = hit_i;
   assign hit_bus.filter = hit_filter_i;
   wire        covered = (hit_bus.filter >= 4'(`CFBP_FIRST_FILTER)) &&
                         (hit_bus.filter <= 4'(`CFBP_LAST_FILTER));
   wire [3:0]  sel_field =
      (hit_filter_i == 4'h4) ? filter4_destination  :
      (hit_filter_i == 4'h5) ? filter5_destination  :
      (hit_filter_i == 4'h6) ? filter6_destination  :
      (hit_filter_i == 4'h7) ? filter7_destination  :
      (hit_filter_i == 4'h8) ? filter8_destination  :
      (hit_filter_i == 4'h9) ? filter9_destination  :
      (hit_filter_i == 4'hA) ? filter10_destination : filter11_destination;
   cfbp_route_s route;
   cfbp_field_decode u_decode (
      .field_i (sel_field),
      .route_o (route)
   );
   assign hit_bus.to_fifo    = route.to_fifo;
   assign hit_bus.buffer_num = route.buffer_num;
   assign hit_bus.store      = hit_bus.hit & covered;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         store_reg <= 1'b0;
         fifo_reg  <= 1'b0;
         buf_reg   <= 4'h0;
      end else begin
         store_reg <= hit_bus.store;
         fifo_reg  <= hit_bus.store & hit_bus.to_fifo;
         buf_reg   <= hit_bus.store ? hit_bus.buffer_num : buf_reg;
      end
   end
   assign store_o        = store_reg;
   assign store_fifo_o   = fifo_reg;
   assign store_buffer_o = buf_reg;
   // ****************************************
   // reset checks
   // ****************************************
   a_reset_clear: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |->
      filter_4_to_7_dest_select_reg == 16'h0000 &&
      filter_8_to_11_dest_select_reg == 16'h0000)
      else $error("fields not cleared by reset");
   a_reset_outputs: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> !wb_ack_o && !wb_err_o && wb_dat_o == 32'h0000_0000 &&
      !store_o && !store_fifo_o && store_buffer_o == 4'h0 &&
      dest_4_to_7_o == 16'h0000 && dest_8_to_11_o == 16'h0000)
      else $error("outputs not cleared by reset");

   // ****************************************
   // bus answer checks
   // ****************************************
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_err_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_err_o |=> !wb_err_o)
      else $error("err held too long");
   a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      req && mapped |=> wb_ack_o && !wb_err_o)
      else $error("mapped request not acknowledged");
   a_err_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !mapped |=> wb_err_o && !wb_ack_o)
      else $error("unmapped request not refused");
   a_no_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      !req |=> !wb_ack_o && !wb_err_o)
      else $error("answer without request");
   a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !mapped |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_unmapped_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !mapped |=> $stable(filter_4_to_7_dest_select_reg) &&
      $stable(filter_8_to_11_dest_select_reg))
      else $error("unmapped write changed a field");

   // ****************************************
   // register checks
   // ****************************************
   a_f47_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_f47 && wb_sel_i[1:0] == 2'b11 |=> wb_ack_o &&
      filter_4_to_7_dest_select_reg == $past(wb_dat_i[15:0]))
      else $error("filters 4-7 write lost");
   a_f811_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_f811 && wb_sel_i[1:0] == 2'b11 |=> wb_ack_o &&
      filter_8_to_11_dest_select_reg == $past(wb_dat_i[15:0]))
      else $error("filters 8-11 write lost");
   a_lane0_only: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_f47 && wb_sel_i[1:0] == 2'b01 |=>
      filter_4_to_7_dest_select_reg[15:8] == $past(filter_4_to_7_dest_select_reg[15:8]) &&
      filter_4_to_7_dest_select_reg[7:0] == $past(wb_dat_i[7:0]))
      else $error("filters 4-7 lane 0 write wrong");
   a_lane1_only: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_f811 && wb_sel_i[1:0] == 2'b10 |=>
      filter_8_to_11_dest_select_reg[7:0] == $past(filter_8_to_11_dest_select_reg[7:0]) &&
      filter_8_to_11_dest_select_reg[15:8] == $past(wb_dat_i[15:8]))
      else $error("filters 8-11 lane 1 write wrong");
   a_idle_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_f47 && !wr_f811 |=> $stable(filter_4_to_7_dest_select_reg) &&
      $stable(filter_8_to_11_dest_select_reg))
      else $error("field changed without a write");
   a_f47_read: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && sel_f47 |=> wb_ack_o &&
      wb_dat_o == {16'h0000, $past(filter_4_to_7_dest_select_reg)})
      else $error("filters 4-7 read wrong");
   a_f811_read: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && sel_f811 |=> wb_ack_o &&
      wb_dat_o == {16'h0000, $past(filter_8_to_11_dest_select_reg)})
      else $error("filters 8-11 read wrong");

   // ****************************************
   // field placement checks
   // ****************************************
   a_f4_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h4 |=>
      store_buffer_o == $past(filter_4_to_7_dest_select_reg[3:0]))
      else $error("filter 4 field wrong");
   a_f5_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h5 |=>
      store_buffer_o == $past(filter_4_to_7_dest_select_reg[7:4]))
      else $error("filter 5 field wrong");
   a_f6_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h6 |=>
      store_buffer_o == $past(filter_4_to_7_dest_select_reg[11:8]))
      else $error("filter 6 field wrong");
   a_f7_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h7 |=>
      store_buffer_o == $past(filter_4_to_7_dest_select_reg[15:12]))
      else $error("filter 7 field wrong");
   a_f8_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h8 |=>
      store_buffer_o == $past(filter_8_to_11_dest_select_reg[3:0]))
      else $error("filter 8 field wrong");
   a_f9_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h9 |=>
      store_buffer_o == $past(filter_8_to_11_dest_select_reg[7:4]))
      else $error("filter 9 field wrong");
   a_f10_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'hA |=>
      store_buffer_o == $past(filter_8_to_11_dest_select_reg[11:8]))
      else $error("filter 10 field wrong");
   a_f11_field: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'hB |=>
      store_buffer_o == $past(filter_8_to_11_dest_select_reg[15:12]))
      else $error("filter 11 field wrong");

   // ****************************************
   // routing checks
   // ****************************************
   a_fifo_route: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && covered && sel_field == 4'hF |=> store_o && store_fifo_o)
      else $error("fifo code not routed to fifo");
   a_buffer_route: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && covered && sel_field != 4'hF |=> store_o && !store_fifo_o &&
      store_buffer_o == $past(sel_field))
      else $error("buffer code not routed to buffer");
   a_store_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i >= 4'h4 && hit_filter_i <= 4'hB |=> store_o)
      else $error("covered hit not stored");
   a_uncovered_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && (hit_filter_i < 4'h4 || hit_filter_i > 4'hB) |=> !store_o)
      else $error("uncovered hit stored");
   a_no_hit_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !hit_i |=> !store_o && !store_fifo_o)
      else $error("store without hit");
   a_buf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(hit_i && hit_filter_i >= 4'h4 && hit_filter_i <= 4'hB) |=>
      $stable(store_buffer_o))
      else $error("buffer number changed without hit");
   a_fifo_with_store: assert property (@(posedge clk_i) disable iff (rst_i)
      store_fifo_o |-> store_o)
      else $error("fifo store without store");
   a_f7_fifo: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'h7 && filter_4_to_7_dest_select_reg[15:12] == 4'hF |=>
      store_fifo_o)
      else $error("filter 7 fifo code not honoured");
   a_f11_fifo: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_i && hit_filter_i == 4'hB && filter_8_to_11_dest_select_reg[15:12] == 4'hF |=>
      store_fifo_o)
      else $error("filter 11 fifo code not honoured");

   // ****************************************
   // cover
   // ****************************************
   c_fifo_hit: cover property (@(posedge clk_i) disable iff (rst_i) store_fifo_o);
   c_buf_hit: cover property (@(posedge clk_i) disable iff (rst_i) store_o && !store_fifo_o);
   c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_f811);
   c_unmapped: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
   c_read: cover property (@(posedge clk_i) disable iff (rst_i) req && !wb_we_i && mapped);
endmodule : cfbp_filter_dest

/* File: core/cfbp_hit_if.sv */
/*
 interface carrying a filter hit and its resolved destination inside cfbp_filter_dest.
 assumes one clock domain; no clocking block.
*/
`timescale 1ns/1ps
interface cfbp_hit_if;
   logic       hit;
   logic [3:0] filter;
   logic       to_fifo;
   logic [3:0] buffer_num;
   logic       store;
   modport src (output hit, output filter, input to_fifo, input buffer_num, input store);
   modport dec (input hit, input filter, output to_fifo, output buffer_num, output store);
endinterface : cfbp_hit_if

/* File: core/cfbp_pkg.sv */
/*
 types for the filter destination select block.
 assumes cfbp_regs.svh is on the include path.
*/
`include "cfbp_regs.svh"
package cfbp_pkg;
   // ****************************************
   // types
   // ****************************************
   typedef logic [3:0]  cfbp_dest_t;
   typedef logic [15:0] cfbp_word_t;
   typedef struct packed {
      logic       to_fifo;
      logic [3:0] buffer_num;
   } cfbp_route_s;
endpackage : cfbp_pkg

/* File: core/cfbp_regs.svh */
/*
 constants for the filter destination select block: offsets, fields, reset values.
 assumes inclusion by bare name from any design file.
*/
`ifndef CFBP_REGS_SVH
`define CFBP_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CFBP_OFS_F4TO7      4'h0
`define CFBP_OFS_F8TO11     4'h4
// ****************************************
// fields and values
// ****************************************
`define CFBP_FIELD_W        4
`define CFBP_FIELDS_PER_REG 4
`define CFBP_REG_W          16
`define CFBP_RST_F4TO7      16'h0000
`define CFBP_RST_F8TO11     16'h0000
`define CFBP_FIFO_CODE      4'hF
`define CFBP_FIRST_FILTER   4
`define CFBP_LAST_FILTER    11
`endif

/* File: verif/cfbp_hit_src.sv */
/*
 partner: far-side filter match source, one-cycle hit per request.
 assumes clk_i is shared with the block under test.
*/
`timescale 1ns/1ps
module cfbp_hit_src (
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic [3:0] filt_i,
   output logic            hit_o,
   output logic      [3:0] filter_o
);
   initial begin
      hit_o    = 1'b0;
      filter_o = 4'h5;
   end
   // idle filter lines toggle so stale values never look valid
   always @(posedge clk_i) begin
      hit_o    <= req_i;
      filter_o <= req_i ? filt_i : ~filter_o;
   end
endmodule : cfbp_hit_src

/* File: verif/tb_top.sv */
/*
 testbench for the filter destination select block.
 assumes the design's wishbone contract and the hit source partner.
*/
`timescale 1ns/1ps
module tb_top;
   import cfbp_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0, filt = 4'h0, hflt;
   logic [31:0] dat = 32'h0, rdat, q;
   logic        ack, err, hit, store, fifo, e;
   logic [3:0]  sbuf;
   cfbp_word_t  d47, d811;
   int          n_errors = 0, checks_done = 0;
   logic [3:0]  r_adr [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4};
   logic [15:0] r_dat [9] = '{16'hF21E, 16'h3A50, 16'h1C00, 16'hF000, 16'h0009,
                              16'h0070, 16'h0B00, 16'hF000, 16'h0000};
   logic [3:0]  r_flt [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'h8};
   logic [4:0]  r_exp [9] = '{5'h0E, 5'h05, 5'h0C, 5'h1F, 5'h09, 5'h07, 5'h0B, 5'h1F, 5'h00};

   always #5 clk_i = ~clk_i;

   cfbp_hit_src cfbp_hit_src_i (.clk_i(clk_i), .req_i(req), .filt_i(filt), .hit_o(hit),
      .filter_o(hflt));
   cfbp_filter_dest cfbp_filter_dest_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .hit_i(hit), .hit_filter_i(hflt),
      .store_o(store), .store_fifo_o(fifo), .store_buffer_o(sbuf),
      .dest_4_to_7_o(d47), .dest_8_to_11_o(d811));

   task final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      checks_done++;
      if (g !== ex) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, ex, g);
      end
   endtask : chk

   task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1 || err === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         final_report();
      end
      q = rdat; e = err;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
      chk("answer_len", 32'h0, {30'h0, ack, err});
   endtask : wb

   task hitchk(input logic [3:0] f, input logic st, input logic [4:0] ex);
      @(posedge clk_i);
      req <= 1'b1; filt <= f;
      @(posedge clk_i);
      req <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("store", {31'h0, st}, {31'h0, store});
      if (st) chk("route", {27'h0, ex}, {27'h0, fifo, sbuf});
      @(posedge clk_i);
      chk("store_len", 32'h0, {31'h0, store});
   endtask : hitchk

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("rst_d47", 32'h0, {16'h0, d47});
      wb(1'b0, 4'h4, 32'h0, 4'hF);
      chk("rst_read", 32'h0, q);
      for (int k = 0; k < 9; k++) begin
         wb(1'b1, r_adr[k], {16'hABCD, r_dat[k]}, 4'hF);
         wb(1'b0, r_adr[k], 32'h0, 4'hF);
         chk("readback", {16'h0, r_dat[k]}, q);
         chk("dest_out", {16'h0, r_dat[k]}, {16'h0, r_adr[k][2] ? d811 : d47});
         hitchk(r_flt[k], 1'b1, r_exp[k]);
      end
      wb(1'b1, 4'h0, 32'hFFFF_1234, 4'h1);
      chk("lane0", 32'h0000F034, {16'h0, d47});
      wb(1'b1, 4'h8, 32'hFFFF, 4'hF);
      chk("unmapped_err", 32'h1, {31'h0, e});
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      chk("unmapped_rd", 32'h0, q);
      chk("unmapped_wr", 32'h0000F034, {d811, d47});
      wb(1'b1, 4'h4, 32'h1234_5AC3, 4'h2);
      chk("lane1", 32'h5A00, {16'h0, d811});
      hitchk(4'h3, 1'b0, 5'h0);
      hitchk(4'hC, 1'b0, 5'h0);
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("rerst", 32'h0, {d811, d47});
      final_report();
   end
endmodule : tb_top
